// file: rtl/ubst_consts.vh
// constants for the uart baud, sleep and time-out core
`ifndef UBST_CONSTS_VH
`define UBST_CONSTS_VH
// register addresses (4-bit register port)
`define UBST_ADDR_DIV_LOW 4'h0
`define UBST_ADDR_DIV_HIGH 4'h1
`define UBST_ADDR_IER 4'h2
`define UBST_ADDR_IDENT 4'h3
`define UBST_ADDR_LINE_FMT 4'h4
`define UBST_ADDR_MODEM_CTL 4'h5
`define UBST_ADDR_LINE_STATE 4'h6
`define UBST_ADDR_EFR 4'h7
`define UBST_ADDR_SAMPLE 4'h8
`define UBST_ADDR_STATUS 4'h9
// field positions
`define UBST_IER_SLEEP_BIT 4
`define UBST_EFR_ENH_BIT 4
`define UBST_LFMT_BREAK_BIT 6
`define UBST_LFMT_PAR_BIT 3
`define UBST_LFMT_STOP_BIT 2
`define UBST_MCTL_PRESC_BIT 7
`define UBST_LSR_BREAK_BIT 4
// reset values
`define UBST_LINE_FMT_RST 8'h1D
`define UBST_SAMPLE_RST 8'h00
// interrupt identification codes
`define UBST_IDENT_NONE 6'h01
`define UBST_IDENT_TIMEOUT 6'h0C
`define UBST_IDENT_RXDATA 6'h04
`define UBST_IDENT_TXEMPTY 6'h02
`define UBST_IDENT_MODEM 6'h00
// timing
`define UBST_BASE_SAMPLE 6'd16
`define UBST_TIMEOUT_CHARS 3'd4
`define UBST_PRESC_DIV 2'd3
`endif

// file: rtl/ubst_core.v
// uart baud generator, sleep control, receive time-out and break logic
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "ubst_consts.vh"
module ubst_core #(
  parameter DIV_W = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire rx_i,
  input wire [3:0] modem_in_i,
  input wire tx_data_i,
  input wire tx_fifo_empty_i,
  input wire tx_shift_empty_i,
  input wire rx_fifo_empty_i,
  input wire rx_above_trig_i,
  input wire rx_stop_mid_i,
  input wire rx_fifo_rd_i,
  input wire tx_fifo_wr_i,
  input wire line_err_i,
  input wire modem_chg_i,
  output wire tx_o,
  output wire irq_n_o,
  output wire baud_tick_o,
  output wire uart_clk_en_o,
  output reg sleep_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] div_low_r;
  reg [7:0] div_high_r;
  reg [7:0] interrupt_enable_reg_r;
  reg [7:0] line_format_reg_r;
  reg [7:0] modem_control_reg_r;
  reg [7:0] enhanced_feature_reg_r;
  reg [3:0] sample_reduction_field_r;
  reg [3:0] sample_extension_field_r;
  reg [1:0] presc_cnt_r;
  reg [DIV_W-1:0] div_cnt_r;
  reg [5:0] samp_cnt_r;
  reg [11:0] char_cnt_r;
  reg [2:0] to_chars_r;
  reg timeout_pend_r;
  reg [11:0] low_cnt_r;
  reg break_det_r;
  reg rx_d_r;
  reg [3:0] modem_d_r;
  wire [DIV_W-1:0] divisor;
  wire [5:0] sample_rate;
  wire presc_tick;
  wire div_tick;
  wire bit_tick;
  wire [11:0] frame_samples;
  wire [5:0] ident_code;
  wire [7:0] line_state_reg;
  wire sleep_ok;
  wire wake;

  // frame length in bits from word length, parity and stop setting
  function [3:0] frame_bits;
    input [7:0] fmt;
    begin
      frame_bits = 4'd6 + {2'b00, fmt[1:0]} + {3'b000, fmt[`UBST_LFMT_PAR_BIT]}
                   + {3'b000, fmt[`UBST_LFMT_STOP_BIT]};
    end
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // divisor bytes are not reset so a programmed divisor survives reset
  always @(posedge clk_sys_i) begin
    if (reg_wr_i && reg_addr_i == `UBST_ADDR_DIV_LOW) begin
      div_low_r <= reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == `UBST_ADDR_DIV_HIGH) begin
      div_high_r <= reg_wdata_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      interrupt_enable_reg_r <= 8'h00;
      line_format_reg_r <= `UBST_LINE_FMT_RST;
      modem_control_reg_r <= 8'h00; // divide-by-1 after reset
      enhanced_feature_reg_r <= 8'h00;
      sample_reduction_field_r <= 4'h0;
      sample_extension_field_r <= 4'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `UBST_ADDR_IER: interrupt_enable_reg_r <= reg_wdata_i;
        `UBST_ADDR_LINE_FMT: line_format_reg_r <= reg_wdata_i;
        `UBST_ADDR_MODEM_CTL: modem_control_reg_r <= reg_wdata_i;
        `UBST_ADDR_EFR: enhanced_feature_reg_r <= reg_wdata_i;
        `UBST_ADDR_SAMPLE: begin
          sample_reduction_field_r <= reg_wdata_i[3:0];
          sample_extension_field_r <= reg_wdata_i[7:4];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  assign divisor = {div_high_r, div_low_r};
  assign sample_rate = `UBST_BASE_SAMPLE - {2'b00, sample_reduction_field_r}
                       + {2'b00, sample_extension_field_r};
  assign presc_tick = !modem_control_reg_r[`UBST_MCTL_PRESC_BIT] ||
                      (presc_cnt_r == `UBST_PRESC_DIV);
  // compare with >= so a count left above a newly shrunk limit wraps at once,
  // instead of running all the way round the counter
  assign div_tick = presc_tick && (divisor != 16'h0000) &&
                    (div_cnt_r >= divisor - 16'h0001);
  assign bit_tick = div_tick && (samp_cnt_r >= sample_rate - 6'd1);
  assign baud_tick_o = bit_tick; // shared by tx and rx

  // counters run only while the uart clock is enabled
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      presc_cnt_r <= 2'd0;
      div_cnt_r <= {DIV_W{1'b0}};
      samp_cnt_r <= 6'd0;
    end else if (!sleep_o) begin
      presc_cnt_r <= presc_tick ? 2'd0 : presc_cnt_r + 2'd1;
      if (divisor == 16'h0000) begin
        div_cnt_r <= {DIV_W{1'b0}}; // no baud clock
        samp_cnt_r <= 6'd0;
      end else if (presc_tick) begin
        div_cnt_r <= div_tick ? {DIV_W{1'b0}} : div_cnt_r + 16'h0001;
        if (div_tick) begin
          samp_cnt_r <= bit_tick ? 6'd0 : samp_cnt_r + 6'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive time-out and break detection
  // ----------------------------------------------------------------
  assign frame_samples = {8'h00, frame_bits(line_format_reg_r)};

  // counts character times since last stop bit or fifo read
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      char_cnt_r <= 12'd0;
      to_chars_r <= 3'd0;
      timeout_pend_r <= 1'b0;
    end else if (rx_stop_mid_i || rx_fifo_rd_i) begin
      char_cnt_r <= 12'd0;
      to_chars_r <= 3'd0;
      timeout_pend_r <= 1'b0;
    end else if (!sleep_o && bit_tick && !rx_fifo_empty_i && !rx_above_trig_i) begin
      if (char_cnt_r == frame_samples - 12'd1) begin
        char_cnt_r <= 12'd0;
        if (to_chars_r == `UBST_TIMEOUT_CHARS - 3'd1) begin
          timeout_pend_r <= 1'b1;
        end else begin
          to_chars_r <= to_chars_r + 3'd1;
        end
      end else begin
        char_cnt_r <= char_cnt_r + 12'd1;
      end
    end
  end

  // rx low for more than one whole frame flags a break
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      low_cnt_r <= 12'd0;
      break_det_r <= 1'b0;
    end else if (rx_i) begin
      low_cnt_r <= 12'd0;
      break_det_r <= 1'b0;
    end else if (bit_tick) begin
      if (low_cnt_r > frame_samples) begin
        break_det_r <= 1'b1;
      end else begin
        low_cnt_r <= low_cnt_r + 12'd1;
      end
    end
  end

  // break control forces tx low until cleared
  assign tx_o = line_format_reg_r[`UBST_LFMT_BREAK_BIT] ? 1'b0 : tx_data_i;

  // ----------------------------------------------------------------
  // interrupt identification
  // ----------------------------------------------------------------
  // priority: line status, time-out / rx data, tx empty, modem
  assign ident_code =
    (interrupt_enable_reg_r[2] && (line_err_i || break_det_r)) ? 6'h06 :
    (interrupt_enable_reg_r[0] && timeout_pend_r) ? `UBST_IDENT_TIMEOUT :
    (interrupt_enable_reg_r[0] && rx_above_trig_i) ? `UBST_IDENT_RXDATA :
    (interrupt_enable_reg_r[1] && tx_fifo_empty_i) ? `UBST_IDENT_TXEMPTY :
    (interrupt_enable_reg_r[3] && modem_chg_i) ? `UBST_IDENT_MODEM :
    `UBST_IDENT_NONE;
  // with enable bits 3:0 zero every source is masked, so polling only
  assign irq_n_o = ident_code[0];

  assign line_state_reg = {1'b0, tx_fifo_empty_i && tx_shift_empty_i, tx_fifo_empty_i,
                           break_det_r, 3'b000, !rx_fifo_empty_i};

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  assign sleep_ok = enhanced_feature_reg_r[`UBST_EFR_ENH_BIT] &&
                    interrupt_enable_reg_r[`UBST_IER_SLEEP_BIT] &&
                    rx_i && !break_det_r && tx_fifo_empty_i && tx_shift_empty_i &&
                    (ident_code == `UBST_IDENT_NONE || ident_code == `UBST_IDENT_TXEMPTY) &&
                    rx_fifo_empty_i;
  assign wake = (rx_i != rx_d_r) || (modem_in_i != modem_d_r) || tx_fifo_wr_i;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sleep_o <= 1'b0;
      rx_d_r <= 1'b1;
      modem_d_r <= 4'h0;
    end else begin
      rx_d_r <= rx_i;
      modem_d_r <= modem_in_i;
      if (wake || !sleep_ok) begin
        sleep_o <= 1'b0;
      end else begin
        sleep_o <= 1'b1;
      end
    end
  end
  assign uart_clk_en_o = !sleep_o;

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `UBST_ADDR_DIV_LOW: reg_rdata_o <= div_low_r;
        `UBST_ADDR_DIV_HIGH: reg_rdata_o <= div_high_r;
        `UBST_ADDR_IER: reg_rdata_o <= interrupt_enable_reg_r;
        `UBST_ADDR_IDENT: reg_rdata_o <= {2'b00, ident_code};
        `UBST_ADDR_LINE_FMT: reg_rdata_o <= line_format_reg_r;
        `UBST_ADDR_MODEM_CTL: reg_rdata_o <= modem_control_reg_r;
        `UBST_ADDR_LINE_STATE: reg_rdata_o <= line_state_reg;
        `UBST_ADDR_EFR: reg_rdata_o <= enhanced_feature_reg_r;
        `UBST_ADDR_SAMPLE: reg_rdata_o <= {sample_extension_field_r, sample_reduction_field_r};
        `UBST_ADDR_STATUS: reg_rdata_o <= {5'h00, timeout_pend_r, break_det_r, sleep_o};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule // ubst_core

// file: sim/tb.sv
// self-checking bench for the uart baud, sleep and time-out core
`timescale 1ns/1ps
module tb;
  reg clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, go = 1'b0;
  reg [3:0] reg_addr_i = 4'h0, modem_in_i = 4'h0;
  reg [7:0] reg_wdata_i = 8'h00, low_ticks = 8'h00, d;
  reg tx_data_i = 1'b1, rx_fifo_empty_i = 1'b1, rx_stop_mid_i = 1'b0;
  reg rx_fifo_rd_i = 1'b0, tx_fifo_wr_i = 1'b0, one = 1'b1, zero = 1'b0;
  wire [7:0] reg_rdata_o;
  wire rx_i, tx_o, irq_n_o, baud_tick_o, uart_clk_en_o, sleep_o;
  integer fails = 0, n_compared = 0, cyc = 0, per, i, dv, pre, red, ext, woke;
  ubst_core i_dut (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rx_i, .modem_in_i, .tx_data_i, .tx_fifo_empty_i(one),
    .tx_shift_empty_i(one), .rx_fifo_empty_i, .rx_above_trig_i(zero), .rx_stop_mid_i,
    .rx_fifo_rd_i, .tx_fifo_wr_i, .line_err_i(zero), .modem_chg_i(zero), .tx_o,
    .irq_n_o, .baud_tick_o, .uart_clk_en_o, .sleep_o);
  ubst_remote i_remote (.clk_sys_i, .baud_tick_i(baud_tick_o), .go_i(go),
    .low_ticks_i(low_ticks), .rx_o(rx_i));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
    end
  endtask
  // the tick is combinational, so it is looked at on the falling edge
  task ticks(input integer n);
    repeat (n) begin
      @(negedge clk_sys_i);
      while (baud_tick_o !== 1'b1) @(negedge clk_sys_i);
    end
  endtask
  task conclude;
    begin
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // guard against a hang; the whole run needs well under this many cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      conclude;
    end
  end
  initial begin
    d = $urandom(22214);
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(4'h3);
    chk(d, 8'h01);
    chk(irq_n_o, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    per = 0;
    repeat (200) @(negedge clk_sys_i) if (baud_tick_o === 1'b1) per = per + 1;
    chk(per, 0);
    // ------------------------------------------------------------
    // bit period against prescaler, divisor and sample rate
    // ------------------------------------------------------------
    for (i = 0; i < 4; i = i + 1) begin
      dv = (i == 3) ? 257 : 1 + $urandom % 6;
      pre = (i == 1) ? 4 : 1;
      red = i * 3;
      ext = i * 5;
      wr(4'h0, dv[7:0]);
      wr(4'h1, dv[15:8]);
      if (i > 0) wr(4'h5, (pre == 4) ? 8'h80 : 8'h00);
      wr(4'h8, {ext[3:0], red[3:0]});
      ticks(2);
      per = 1;
      @(negedge clk_sys_i);
      while (baud_tick_o !== 1'b1) begin
        per = per + 1;
        @(negedge clk_sys_i);
      end
      chk(per, pre * dv * (16 - red + ext));
    end
    $display("baud test done");
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h8, 8'h0C);
    wr(4'h4, 8'h00);
    wr(4'h2, 8'h01);
    // six-bit frames, so four characters are 24 bit times
    @(posedge clk_sys_i);
    rx_fifo_empty_i <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      ticks((i == 2) ? 8 : 20);
      rd(4'h3);
      chk(d, (i == 2) ? 8'h0C : 8'h01);
      if (i == 2) chk(irq_n_o, 1'b0);
      @(posedge clk_sys_i);
      rx_stop_mid_i <= (i == 0);
      rx_fifo_rd_i <= (i == 2);
      @(posedge clk_sys_i);
      rx_stop_mid_i <= 1'b0;
      rx_fifo_rd_i <= 1'b0;
    end
    rx_fifo_empty_i <= 1'b1;
    $display("time-out test done");
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk_sys_i);
      low_ticks <= i ? 8'd40 : 8'd4;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      ticks(i ? 12 : 8);
      rd(4'h9);
      chk(d[1], i);
    end
    ticks(32);
    wr(4'h4, 8'h40);
    @(negedge clk_sys_i);
    chk(tx_o, 1'b0);
    wr(4'h4, 8'h00);
    @(negedge clk_sys_i);
    chk(tx_o, 1'b1);
    $display("break test done");
    wr(4'h2, 8'h10);
    repeat (4) @(negedge clk_sys_i);
    chk(sleep_o, 1'b0);
    wr(4'h7, 8'h10);
    for (i = 0; i < 3; i = i + 1) begin
      repeat (4) @(negedge clk_sys_i);
      chk(sleep_o, 1'b1);
      chk(uart_clk_en_o, 1'b0);
      @(posedge clk_sys_i);
      if (i == 0) modem_in_i <= ~modem_in_i;
      tx_fifo_wr_i <= (i == 1);
      low_ticks <= 8'd1;
      go <= (i == 2);
      @(posedge clk_sys_i);
      tx_fifo_wr_i <= 1'b0;
      go <= 1'b0;
      woke = 0;
      repeat (3) @(negedge clk_sys_i) if (sleep_o === 1'b0) woke = 1;
      chk(woke, 1);
    end
    // baud counters freeze while asleep, so wait on the line rather than on ticks
    wait (rx_i === 1'b1);
    wr(4'h2, 8'h00);
    rx_fifo_empty_i <= 1'b0;
    wr(4'h2, 8'h10);
    repeat (4) @(negedge clk_sys_i);
    chk(sleep_o, 1'b0);
    $display("sleep test done");
    conclude;
  end
endmodule // tb

// file: sim/ubst_core_props.sv
// assertion checker for the uart baud, sleep and time-out core
`timescale 1ns/1ps
`include "ubst_consts.vh"
module ubst_core_props (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire rx_i,
  input wire tx_data_i,
  input wire tx_fifo_empty_i,
  input wire tx_shift_empty_i,
  input wire rx_fifo_empty_i,
  input wire tx_fifo_wr_i,
  input wire tx_o,
  input wire irq_n_o,
  input wire baud_tick_o,
  input wire uart_clk_en_o,
  input wire sleep_o
);
  reg [7:0] ier_r, efr_r, fmt_r, dlo_r, dhi_r;
  // register mirror; the divisor is left unreset, as in the core
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ier_r <= 8'h00;
      efr_r <= 8'h00;
      fmt_r <= `UBST_LINE_FMT_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `UBST_ADDR_IER) ier_r <= reg_wdata_i;
      if (reg_addr_i == `UBST_ADDR_EFR) efr_r <= reg_wdata_i;
      if (reg_addr_i == `UBST_ADDR_LINE_FMT) fmt_r <= reg_wdata_i;
      if (reg_addr_i == `UBST_ADDR_DIV_LOW) dlo_r <= reg_wdata_i;
      if (reg_addr_i == `UBST_ADDR_DIV_HIGH) dhi_r <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_break_hold: assert property (tx_o == (fmt_r[6] ? 1'b0 : tx_data_i))
    else $error("tx line does not follow break bit");
  a_poll_quiet: assert property (ier_r[3:0] == 4'h0 |-> irq_n_o)
    else $error("interrupt raised with all enables clear");
  a_sleep_gate: assert property ($rose(sleep_o) |-> $past(ier_r[4] && efr_r[4]))
    else $error("sleep entered without both enables");
  a_sleep_idle: assert property ($rose(sleep_o)
    |-> $past(rx_i && tx_fifo_empty_i && tx_shift_empty_i))
    else $error("sleep entered with busy line");
  a_rx_held: assert property ($rose(sleep_o) |-> $past(rx_fifo_empty_i))
    else $error("sleep entered with receive data held");
  a_clk_off: assert property (uart_clk_en_o != sleep_o)
    else $error("clock enable disagrees with sleep");
  a_tx_wake: assert property (sleep_o && tx_fifo_wr_i |=> !sleep_o)
    else $error("no wake on transmit write");
  a_div_zero: assert property (({dhi_r, dlo_r} == 16'h0000)[*4] |-> !baud_tick_o)
    else $error("tick with zero divisor");
endmodule // ubst_core_props
bind ubst_core ubst_core_props i_props (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .rx_i, .tx_data_i, .tx_fifo_empty_i, .tx_shift_empty_i, .rx_fifo_empty_i,
  .tx_fifo_wr_i, .tx_o, .irq_n_o, .baud_tick_o, .uart_clk_en_o, .sleep_o);

// file: sim/ubst_remote.sv
// remote serial station model driving the receive line
`timescale 1ns/1ps
module ubst_remote (
  input wire clk_sys_i,
  input wire baud_tick_i,
  input wire go_i,
  input wire [7:0] low_ticks_i,
  output reg rx_o
);
  reg [7:0] cnt_r = 8'h00;
  initial rx_o = 1'b1;
  // line idles high; holds low a whole number of bit times, then releases
  always @(posedge clk_sys_i) begin
    if (go_i) begin
      rx_o <= 1'b0;
      cnt_r <= low_ticks_i;
    end else if (!rx_o && baud_tick_i) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01) rx_o <= 1'b1;
    end
  end
endmodule // ubst_remote
